// >>> design/cicy_pkg.sv
// package for the four-instruction decode/execute slice of a 4-bit core
// assumes 10-bit instruction words and 4-bit accumulator and y register
package cicy_pkg;
  // ==========================================================
  // widths and opcodes
  localparam int unsigned INSTR_W = 10;
  localparam int unsigned DATA_W = 4;
  localparam logic [INSTR_W-1:0] OP_COMPLEMENT_ACC = 10'h01C;
  localparam logic [INSTR_W-1:0] OP_SELECT_CERAMIC = 10'h29A;
  localparam logic [INSTR_W-1:0] OP_SELECT_RC = 10'h29B;
  localparam logic [INSTR_W-1:0] OP_DECREMENT_Y = 10'h017;
  // ==========================================================
  // values
  localparam logic [DATA_W-1:0] ACC_RESET = 4'h0;
  localparam logic [DATA_W-1:0] Y_RESET = 4'h0;
  localparam logic [DATA_W-1:0] Y_ONE = 4'h1;
  localparam logic [DATA_W-1:0] Y_SKIP_VALUE = 4'hF;
  localparam logic OSC_RUN_RESET = 1'h1;
  localparam logic SKIP_RESET = 1'h0;
  localparam logic DONE_RESET = 1'h0;
  // ==========================================================
  // main clock source
  typedef enum logic [1:0] {
    CICY_SRC_ONCHIP,
    CICY_SRC_CERAMIC,
    CICY_SRC_RC
  } cicy_clk_src_t;
endpackage : cicy_pkg

// >>> design/cicy_decode.sv
// opcode decoder for the four instructions of this slice
// assumes a valid-qualified instruction word from the same clock
`timescale 1ns/1ps
module cicy_decode
  import cicy_pkg::*;
(
  input wire logic [INSTR_W-1:0] instr,
  input wire logic instrValid,
  output logic complementAccOp,
  output logic selectCeramicOp,
  output logic selectRcOp,
  output logic decrementYOp
);
  always_comb begin
    complementAccOp = instrValid && (instr == OP_COMPLEMENT_ACC);
    selectCeramicOp = instrValid && (instr == OP_SELECT_CERAMIC);
    selectRcOp = instrValid && (instr == OP_SELECT_RC);
    decrementYOp = instrValid && (instr == OP_DECREMENT_Y);
  end
endmodule : cicy_decode

// >>> design/cicy_exec.sv
// execute slice: complement accumulator, clock select, decrement y
// assumes the core presents one instruction per cycle with instrValid,
// and honours skipNext by discarding the next presented instruction
// runs on the system clock only; rst_b is synchronous and active low
// clkSource and onChipOscRun are requests to oscillator circuits
// outside this slice, which act on them in their own time
//
// Notes on behaviour
// RL1: opcode 01C replaces accumulator with its bitwise complement, one cycle
// RL2: opcode 29A selects ceramic main clock and stops on-chip oscillator
// RL3: opcode 29B selects RC main clock and stops on-chip oscillator
// RL4: opcode 017 decrements Y modulo 16, carry untouched
// RL5: after Y decrement, skip next instruction when new Y equals 15
`timescale 1ns/1ps
module cicy_exec
  import cicy_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [INSTR_W-1:0] instr,
  input wire logic instrValid,
  input wire logic accLoad,
  input wire logic [DATA_W-1:0] accLoadData,
  input wire logic yLoad,
  input wire logic [DATA_W-1:0] yLoadData,
  output logic [DATA_W-1:0] acc,
  output logic [DATA_W-1:0] yReg,
  output logic skipNext,
  output logic [1:0] clkSource,
  output logic onChipOscRun,
  output logic instrDone
);
  // ==========================================================
  // decode
  logic complementAccOp;
  logic selectCeramicOp;
  logic selectRcOp;
  logic decrementYOp;
  logic execValid;

  // a skipped word is fetched but must have no effect
  assign execValid = instrValid && !skipNext;

  cicy_decode u_decode (
    .instr(instr),
    .instrValid(execValid),
    .complementAccOp(complementAccOp),
    .selectCeramicOp(selectCeramicOp),
    .selectRcOp(selectRcOp),
    .decrementYOp(decrementYOp)
  );

  // ==========================================================
  // shared arithmetic
  // the y group and the skip group both need the decremented value;
  // one function keeps their idea of the wrap identical
  function automatic logic [DATA_W-1:0] cicy_y_minus_one(
    input logic [DATA_W-1:0] y
  );
    return y - Y_ONE;
  endfunction : cicy_y_minus_one

  function automatic logic cicy_lands_on_skip(
    input logic [DATA_W-1:0] y
  );
    return cicy_y_minus_one(y) == Y_SKIP_VALUE;
  endfunction : cicy_lands_on_skip

  // ==========================================================
  // accumulator
  logic [DATA_W-1:0] acc_ff;
  logic [DATA_W-1:0] nxt_acc;

  always_comb begin
    nxt_acc = acc_ff;
    // side load from the rest of the core; complement wins a clash
    if (accLoad) begin
      nxt_acc = accLoadData;
    end
    // RL1: complement accumulator
    if (complementAccOp) begin
      nxt_acc = ~acc_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      acc_ff <= ACC_RESET;
    end else begin
      acc_ff <= nxt_acc;
    end
  end

  // ==========================================================
  // y address register
  logic [DATA_W-1:0] y_ff;
  logic [DATA_W-1:0] nxt_y;

  always_comb begin
    nxt_y = y_ff;
    // side load from the rest of the core; the decrement wins a clash
    if (yLoad) begin
      nxt_y = yLoadData;
    end
    // RL4: decrement y wrapping
    if (decrementYOp) begin
      nxt_y = cicy_y_minus_one(y_ff);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      y_ff <= Y_RESET;
    end else begin
      y_ff <= nxt_y;
    end
  end

  // ==========================================================
  // skip flag
  // counts presented words, not clocks: idle cycles leave a skip
  // pending until the core offers the next word
  logic skip_ff;
  logic nxt_skip;

  always_comb begin
    nxt_skip = skip_ff;
    // the presented word consumes a pending skip
    if (instrValid) begin
      nxt_skip = 1'h0;
    end
    // RL5: skip on fifteen
    // set after clear, so a decrement landing on fifteen wins
    if (decrementYOp) begin
      nxt_skip = cicy_lands_on_skip(y_ff);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      skip_ff <= SKIP_RESET;
    end else begin
      skip_ff <= nxt_skip;
    end
  end

  // ==========================================================
  // main clock source
  // one-way in this slice: only reset brings back the on-chip source
  cicy_clk_src_t src_ff;
  cicy_clk_src_t nxt_src;

  always_comb begin
    nxt_src = src_ff;
    // RL2: ceramic source
    if (selectCeramicOp) begin
      nxt_src = CICY_SRC_CERAMIC;
    end
    // RL3: rc source
    if (selectRcOp) begin
      nxt_src = CICY_SRC_RC;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      src_ff <= CICY_SRC_ONCHIP;
    end else begin
      src_ff <= nxt_src;
    end
  end

  // ==========================================================
  // on-chip oscillator run request
  // nothing here restarts it; a user who stops it keeps the new
  // source until the next reset
  logic osc_ff;
  logic nxt_osc;

  always_comb begin
    nxt_osc = osc_ff;
    // RL2 RL3: either select stops it
    if (selectCeramicOp || selectRcOp) begin
      nxt_osc = 1'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      osc_ff <= OSC_RUN_RESET;
    end else begin
      osc_ff <= nxt_osc;
    end
  end

  // ==========================================================
  // executed-word pulse
  // pulses for any executed word, known opcode or not
  logic done_ff;
  logic nxt_done;

  always_comb begin
    nxt_done = execValid;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      done_ff <= DONE_RESET;
    end else begin
      done_ff <= nxt_done;
    end
  end

  // ==========================================================
  // outputs
  // all straight from flip-flops, so the core sees no decode glitches
  assign acc = acc_ff;
  assign yReg = y_ff;
  assign skipNext = skip_ff;
  assign clkSource = src_ff;
  assign onChipOscRun = osc_ff;
  assign instrDone = done_ff;
endmodule : cicy_exec

// >>> verification/cicy_chk.sv
// checker for the execute slice
// assumes binding to cicy_exec
`timescale 1ns/1ps
module cicy_chk
  import cicy_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [INSTR_W-1:0] instr,
  input wire logic instrValid,
  input wire logic [DATA_W-1:0] acc,
  input wire logic [DATA_W-1:0] yReg,
  input wire logic skipNext,
  input wire logic [1:0] clkSource,
  input wire logic onChipOscRun,
  input wire logic instrDone
);
  // ====================
  // assertions
  wire logic tk = instrValid && !skipNext;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  acc_flip_a: assert property (
    tk && instr == OP_COMPLEMENT_ACC |=> acc == ~$past(acc))
    else $error("acc not inverted");
  ceramic_sel_a: assert property (
    tk && instr == OP_SELECT_CERAMIC |=>
      clkSource == CICY_SRC_CERAMIC && !onChipOscRun)
    else $error("ceramic not selected");
  rc_sel_a: assert property (
    tk && instr == OP_SELECT_RC |=> clkSource == CICY_SRC_RC && !onChipOscRun)
    else $error("rc not selected");
  y_dec_a: assert property (
    tk && instr == OP_DECREMENT_Y |=> yReg == $past(yReg) - Y_ONE)
    else $error("y not decremented");
  y_skip_a: assert property (
    tk && instr == OP_DECREMENT_Y |=> skipNext == (yReg == Y_SKIP_VALUE))
    else $error("skip wrong");
  skip_drop_a: assert property (
    instrValid && skipNext |=> !skipNext && !instrDone &&
      $stable(clkSource) && $stable(onChipOscRun))
    else $error("skipped word had an effect");
endmodule : cicy_chk
bind cicy_exec cicy_chk i_cicy_chk (.clk(clk), .rst_b(rst_b), .instr(instr),
  .instrValid(instrValid), .acc(acc), .yReg(yReg), .skipNext(skipNext),
  .clkSource(clkSource), .onChipOscRun(onChipOscRun),
  .instrDone(instrDone));

// >>> verification/cicy_exec_tb.sv
// random instruction stream against a bench model
// assumes cicy_pkg and the checker bind are compiled first
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin fails++; \
  $display("wrong value at %0t: %h not %h", $time, a, e); end end
module cicy_exec_tb;
  import cicy_pkg::*;
  logic clk = 0, rst_b = 0, instrValid = 0, accLoad = 0, yLoad = 0;
  logic [INSTR_W-1:0] instr = '0;
  logic [DATA_W-1:0] accLoadData = '0, yLoadData = '0, acc, yReg;
  logic [DATA_W-1:0] eA = '0, eY = '0;
  logic [1:0] clkSource, eS = '0;
  logic skipNext, onChipOscRun, instrDone, eK = 0, eO = 1, eD = 0, ex;
  int fails = 0, n_compared = 0, seed = 9, k;
  logic corner;
  cicy_exec i_cicy_exec (.clk(clk), .rst_b(rst_b), .instr(instr),
    .instrValid(instrValid), .accLoad(accLoad), .accLoadData(accLoadData),
    .yLoad(yLoad), .yLoadData(yLoadData), .acc(acc), .yReg(yReg),
    .skipNext(skipNext), .clkSource(clkSource),
    .onChipOscRun(onChipOscRun), .instrDone(instrDone));
  // ==========================================================
  // model
  function automatic logic [INSTR_W-1:0] pick_instr(input int sel,
      input logic [INSTR_W-1:0] r);
    case (sel)
      0: return OP_COMPLEMENT_ACC;
      1: return OP_SELECT_CERAMIC;
      2: return OP_SELECT_RC;
      3: return OP_DECREMENT_Y;
      default: return r;
    endcase
  endfunction : pick_instr
  task automatic step;
    if (!rst_b) begin
      eA = ACC_RESET;
      eY = Y_RESET;
      eS = CICY_SRC_ONCHIP;
      eO = OSC_RUN_RESET;
      eK = SKIP_RESET;
      eD = DONE_RESET;
    end else begin
      ex = instrValid && !eK;
      eD = ex;
      if (ex && instr == OP_COMPLEMENT_ACC) eA = ~eA;
      else if (accLoad) eA = accLoadData;
      if (ex && instr == OP_DECREMENT_Y) eY = eY - 4'h1;
      else if (yLoad) eY = yLoadData;
      if (ex && (instr == OP_SELECT_CERAMIC || instr == OP_SELECT_RC)) begin
        eS = (instr == OP_SELECT_RC) ? CICY_SRC_RC : CICY_SRC_CERAMIC;
        eO = 0;
      end
      if (instrValid) eK = ex && instr == OP_DECREMENT_Y && eY == 4'hF;
    end
  endtask : step
  task automatic close_out;
    $display("compared %0d wrong %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  initial begin
    forever #25 clk = ~clk;
  end
  // ==========================================================
  // stimulus and checks
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1;
    for (int i = 0; i < 800; i++) begin
      @(posedge clk);
      step();
      // after each reset: back-to-back decrements from zero force the wrap
      corner = i < 4 || (i >= 403 && i < 407);
      k = corner ? 3 : $unsigned($random(seed)) % 6;
      instr <= pick_instr(k, 10'($random(seed)));
      instrValid <= corner || ($random(seed) & 3) != 0;
      accLoad <= ($random(seed) & 7) == 0;
      yLoad <= !corner && ($random(seed) & 7) == 0;
      // mid-run reset held for three edges; the model resets with it
      if (i == 400) rst_b <= 0;
      if (i == 403) rst_b <= 1;
      accLoadData <= 4'($random(seed));
      yLoadData <= 4'($random(seed));
      #1;
      `CHK(acc, eA)
      `CHK(clkSource, eS)
      `CHK(onChipOscRun, eO)
      `CHK(yReg, eY)
      `CHK(skipNext, eK)
      `CHK(instrDone, eD)
    end
    close_out();
  end
endmodule : cicy_exec_tb
